// ---- inwin_decode.sv ----
// inbound address window decode with page lookup and translation
// assumes register and transaction ports synchronous to sys_clk
`timescale 1ns/10ps
module inwin_decode (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic txn_valid,
    input wire logic [63:0] txn_addr,
    input wire logic txn_dac,
    input wire logic txn_is_io,
    output logic txn_claim,
    output logic txn_window,
    output logic fwd_valid,
    output logic [63:0] fwd_addr,
    output logic [inwin_pkg::DEST_W-1:0] fwd_dest,
    output logic fwd_window,
    output logic [inwin_pkg::PAGE_W-1:0] fwd_page
);
    import inwin_pkg::*;

    logic [ORIGIN_W-1:0] a_origin_q;
    logic [ORIGIN_W-1:0] b_origin_q;
    logic [31:0] a_origin_hi_q;
    logic [31:0] b_origin_hi_q;
    logic [SIZE_W-1:0] a_size_q;
    logic [SIZE_W-1:0] b_size_q;
    logic a_en_q;
    logic b_en_q;
    logic a_pass_q;
    logic b_pass_q;
    logic [63:0] addr_eff;
    logic a_hit;
    logic b_hit;
    logic [PAGE_W-1:0] a_page;
    logic [PAGE_W-1:0] b_page;
    logic [PAGE_W-1:0] sel_page;
    logic [SIZE_W-1:0] sel_size;
    logic sel_pass;
    logic lut_wr;
    logic lut_wr_hi;
    logic [LUT_AW-1:0] lut_wr_idx;
    logic [LUT_AW-1:0] lut_rd_idx;
    logic [11:0] lut_off;
    logic [31:0] lut_lo;
    logic [31:0] lut_hi;
    logic s1_valid_q;
    logic [63:0] s1_addr_q;
    logic s1_win_q;
    logic s1_pass_q;
    logic [63:0] s1_offmask_q;
    logic [PAGE_W-1:0] s1_page_q;
    logic [63:0] xlat_addr;

    // bits of the address compared against the origin for a size code
    function automatic logic [63:0] match_mask(input logic [SIZE_W-1:0] sz);
        match_mask = ~64'h0000_0000_0000_0000 << (MATCH_BASE + {2'b00, sz});
    endfunction

    // page index sits five bits below the compared field
    function automatic logic [PAGE_W-1:0] page_of(input logic [63:0] a,
                                                  input logic [SIZE_W-1:0] sz);
        logic [63:0] sh;
        sh = a >> (PAGE_BASE + {2'b00, sz});
        page_of = sh[PAGE_W-1:0];
    endfunction

    // a 32-bit cycle carries zero above bit 31, so the upper origin must be zero
    assign addr_eff = txn_dac ? txn_addr : {ZERO32, txn_addr[31:0]};

    // hit check per window: enabled, memory space, origin match above size
    always_comb begin
        logic [63:0] a_org;
        logic [63:0] b_org;
        a_org = {a_origin_hi_q, a_origin_q, 15'h0000};
        b_org = {b_origin_hi_q, b_origin_q, 15'h0000};
        a_hit = txn_valid && !txn_is_io && a_en_q &&
                ((addr_eff & match_mask(a_size_q)) == (a_org & match_mask(a_size_q)));
        b_hit = txn_valid && !txn_is_io && b_en_q &&
                ((addr_eff & match_mask(b_size_q)) == (b_org & match_mask(b_size_q)));
    end

    assign a_page = page_of(addr_eff, a_size_q);
    assign b_page = page_of(addr_eff, b_size_q);

    // window A wins if software lets the two windows overlap
    assign txn_claim = a_hit || b_hit;
    assign txn_window = !a_hit;
    assign sel_page = a_hit ? a_page : b_page;
    assign sel_size = a_hit ? a_size_q : b_size_q;
    assign sel_pass = a_hit ? a_pass_q : b_pass_q;
    assign lut_rd_idx = {txn_window, sel_page};

    // lookup writes: lower and upper entries interleave per page
    assign lut_wr = reg_wr_en && (reg_addr >= LUT_BASE) && (reg_addr <= LUT_LAST);
    // index from the offset inside the lookup block: the raw address has
    // bit 8 set for window A, which would land its pages in window B's half
    assign lut_off = reg_addr - LUT_BASE;
    assign lut_wr_hi = reg_addr[2];
    assign lut_wr_idx = lut_off[8:3];

    lut_mem #(.W(32), .AW(LUT_AW)) u_lut_lo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wr_en(lut_wr && !lut_wr_hi),
        .wr_addr(lut_wr_idx),
        .wr_data(reg_wdata),
        .rd_addr(lut_rd_idx),
        .rd_data(lut_lo)
    );

    lut_mem #(.W(32), .AW(LUT_AW)) u_lut_hi (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wr_en(lut_wr && lut_wr_hi),
        .wr_addr(lut_wr_idx),
        .wr_data(reg_wdata),
        .rd_addr(lut_rd_idx),
        .rd_data(lut_hi)
    );

    // sizing register: sizes, enables and translate controls
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_size_q <= '0;
            b_size_q <= '0;
            a_en_q <= 1'b0;
            b_en_q <= 1'b0;
            a_pass_q <= 1'b0;
            b_pass_q <= 1'b0;
        end else if (reg_wr_en && reg_addr == SIZING_OFF) begin
            a_size_q <= reg_wdata[SIZE_A_LSB +: SIZE_W];
            b_size_q <= reg_wdata[SIZE_B_LSB +: SIZE_W];
            a_en_q <= reg_wdata[A_EN_BIT];
            b_en_q <= reg_wdata[B_EN_BIT];
            a_pass_q <= reg_wdata[A_PASS_BIT];
            b_pass_q <= reg_wdata[B_PASS_BIT];
        end
    end

    // window A origins only accept writes once the window is enabled
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_origin_q <= '0;
            a_origin_hi_q <= '0;
        end else if (reg_wr_en && a_en_q) begin
            if (reg_addr == ORIGIN_A_OFF) begin
                a_origin_q <= reg_wdata[31:ORIGIN_LSB];
            end
            if (reg_addr == ORIGIN_A_HI_OFF) begin
                a_origin_hi_q <= reg_wdata;
            end
        end
    end

    // window B origins gated by their own enable
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            b_origin_q <= '0;
            b_origin_hi_q <= '0;
        end else if (reg_wr_en && b_en_q) begin
            if (reg_addr == ORIGIN_B_OFF) begin
                b_origin_q <= reg_wdata[31:ORIGIN_LSB];
            end
            if (reg_addr == ORIGIN_B_HI_OFF) begin
                b_origin_hi_q <= reg_wdata;
            end
        end
    end

    // register reads answer one cycle later; lookup entries read as zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd_en;
            reg_rdata <= '0;
            if (reg_rd_en) begin
                case (reg_addr)
                    ORIGIN_A_OFF: reg_rdata <= {a_origin_q, 11'h000, ORIGIN_ATTR};
                    ORIGIN_B_OFF: reg_rdata <= {b_origin_q, 11'h000, ORIGIN_ATTR};
                    ORIGIN_A_HI_OFF: reg_rdata <= a_origin_hi_q;
                    ORIGIN_B_HI_OFF: reg_rdata <= b_origin_hi_q;
                    SIZING_OFF: begin
                        reg_rdata[SIZE_A_LSB +: SIZE_W] <= a_size_q;
                        reg_rdata[SIZE_B_LSB +: SIZE_W] <= b_size_q;
                        reg_rdata[A_EN_BIT] <= a_en_q;
                        reg_rdata[A_PASS_BIT] <= a_pass_q;
                        reg_rdata[B_EN_BIT] <= b_en_q;
                        reg_rdata[B_PASS_BIT] <= b_pass_q;
                    end
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

    // stage one holds the claimed transaction while the lookup is read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_valid_q <= 1'b0;
            s1_addr_q <= '0;
            s1_win_q <= 1'b0;
            s1_pass_q <= 1'b0;
            s1_offmask_q <= '0;
            s1_page_q <= '0;
        end else begin
            s1_valid_q <= txn_claim;
            s1_addr_q <= addr_eff;
            s1_win_q <= txn_window;
            s1_pass_q <= sel_pass;
            s1_offmask_q <= ~(~64'h0000_0000_0000_0000 << (PAGE_BASE + {2'b00, sel_size}));
            s1_page_q <= sel_page;
        end
    end

    // page translation address replaces everything above the page offset
    assign xlat_addr = ({lut_hi, lut_lo[31:TA_LSB], 10'h000} & ~s1_offmask_q) |
                       (s1_addr_q & s1_offmask_q);

    // stage two: forwarded address, destination and window
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_valid <= 1'b0;
            fwd_addr <= '0;
            fwd_dest <= '0;
            fwd_window <= 1'b0;
            fwd_page <= '0;
        end else begin
            fwd_valid <= s1_valid_q;
            fwd_addr <= s1_pass_q ? s1_addr_q : xlat_addr;
            fwd_dest <= lut_lo[DEST_W-1:0];
            fwd_window <= s1_win_q;
            fwd_page <= s1_page_q;
        end
    end

    // checks
    a_io_never_claimed: assert property (@(posedge sys_clk) disable iff (!rst_n)
        txn_valid && txn_is_io |-> !txn_claim)
        else $error("io transaction was claimed");

    a_claim_needs_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
        txn_claim |-> (a_en_q && !txn_window) || (b_en_q && txn_window))
        else $error("claim by a disabled window");

    a_fwd_after_claim: assert property (@(posedge sys_clk) disable iff (!rst_n)
        txn_claim |-> ##2 fwd_valid && fwd_window == $past(txn_window, 2))
        else $error("forward did not follow claim by two cycles");

    a_passthrough_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        txn_claim && sel_pass |-> ##2 fwd_addr == $past(addr_eff, 2))
        else $error("pass-through address altered");

    a_offset_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
        txn_claim && !sel_pass && sel_size == 5'h03 |->
        ##2 fwd_addr[12:0] == $past(addr_eff[12:0], 2))
        else $error("page offset not kept under translation");

    a_page_index: assert property (@(posedge sys_clk) disable iff (!rst_n)
        txn_claim && sel_size == 5'h00 |-> ##2 fwd_page == $past(addr_eff[14:10], 2))
        else $error("wrong page for smallest window");

    a_origin_a_locked: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr_en && !a_en_q && reg_addr == ORIGIN_A_OFF |=> $stable(a_origin_q))
        else $error("window A origin written while disabled");

    a_origin_b_locked: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr_en && !b_en_q && reg_addr == ORIGIN_B_HI_OFF |=> $stable(b_origin_hi_q))
        else $error("window B upper origin written while disabled");

    a_translate_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !$past(rst_n) |-> !a_pass_q && !b_pass_q)
        else $error("translation not enabled after reset");

    a_attr_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd_en && reg_addr == ORIGIN_B_OFF |=> reg_rvalid && reg_rdata[3:0] == 4'hC)
        else $error("origin attributes not prefetchable 64-bit memory");

    a_size_a_field: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr_en && reg_addr == SIZING_OFF |=> a_size_q == $past(reg_wdata[15:11]))
        else $error("window A size not from bits 15 to 11");
endmodule

// ---- inwin_pkg.sv ----
// constants, register map and field layout of the inbound window decoder
// assumes a simple single-cycle register port and a 10 MHz sys_clk
// How it works
// - lower origin bits are compared with address bits 31 to 15
// - for 64-bit addresses the upper origin supplies bits 63 to 32
// - windows always read back as prefetchable, fixed
// - windows always read back as 64-bit type, placeable anywhere
// - windows are memory only; I/O transactions are never claimed
// - window A size comes from sizing bits 15 to 11
// - every window is split into exactly 32 equal pages
// - window B size comes from sizing bits 7 to 3
// - in pass-through, lookup entry only picks the destination port
// - per-window bit picks pass-through or translated address
// - after reset both windows translate addresses
// - window A enable bit enables both window A origin registers
// - window A origin writes ignored until window A enable is set
// - window B origins gated the same way by window B enable
// - translation replaces the bits above the page offset
// - each page entry holds a fabric destination port number
package inwin_pkg;
    // register byte offsets
    localparam logic [11:0] ORIGIN_A_OFF = 12'h018;
    localparam logic [11:0] ORIGIN_A_HI_OFF = 12'h01C;
    localparam logic [11:0] ORIGIN_B_OFF = 12'h020;
    localparam logic [11:0] ORIGIN_B_HI_OFF = 12'h024;
    localparam logic [11:0] SIZING_OFF = 12'h04C;
    localparam logic [11:0] LUT_BASE = 12'h500;
    localparam logic [11:0] LUT_LAST = 12'h6FC;
    // origin register layout
    localparam int ORIGIN_LSB = 15;
    localparam int ORIGIN_W = 17;
    localparam logic [3:0] ORIGIN_ATTR = 4'hC; // prefetch=1, type=2'b10, io=0
    // sizing register layout
    localparam int SIZE_A_LSB = 11;
    localparam int SIZE_B_LSB = 3;
    localparam int SIZE_W = 5;
    localparam int A_EN_BIT = 16;
    localparam int A_PASS_BIT = 17;
    localparam int B_EN_BIT = 18;
    localparam int B_PASS_BIT = 19;
    // decode geometry
    localparam logic [6:0] MATCH_BASE = 7'd15;
    localparam logic [6:0] PAGE_BASE = 7'd10;
    localparam int PAGE_W = 5;
    localparam int LUT_AW = 6;
    localparam int TA_LSB = 10;
    localparam int DEST_W = 4;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage

// ---- lut_mem.sv ----
// small register-file memory for the page lookup entries
// one write port, one read port with registered data
`timescale 1ns/10ps
module lut_mem #(
    parameter int W = 32,
    parameter int AW = 6
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem [2**AW];

    // storage has no reset; software must program pages before use
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read data registered, one cycle after the address
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ---- fabric_sink.sv ----
// fabric-side partner that takes in forwarded transactions
// assumes fwd_* outputs are registered on sys_clk
`timescale 1ns/10ps
module fabric_sink (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic fwd_valid,
    input wire logic [63:0] fwd_addr,
    input wire logic [inwin_pkg::DEST_W-1:0] fwd_dest,
    output logic [63:0] got_addr,
    output logic [inwin_pkg::DEST_W-1:0] got_dest,
    output int got_count
);
    import inwin_pkg::*;
    // the fabric never stalls, so every forward is taken on its own cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            got_addr <= 64'h0000_0000_0000_0000;
            got_dest <= '0;
            got_count <= 0;
        end else if (fwd_valid) begin
            got_addr <= fwd_addr;
            got_dest <= fwd_dest; // port picks the receiving interface
            got_count <= got_count + 1;
        end
    end
endmodule

// ---- tb_pcix_inbound_window_decode.sv ----
// self-checking bench for the inbound window decoder
// assumes single-cycle register strobes and a 10 MHz sys_clk
`timescale 1ns/10ps
module tb_pcix_inbound_window_decode;
    import inwin_pkg::*;
    typedef struct {
        logic [63:0] a;
        logic dac;
        logic io;
        logic claim;
        logic win;
        logic [63:0] fa;
        logic [3:0] dest;
        logic [4:0] pg;
    } row_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, txn_valid = 1'b0, txn_dac = 1'b0, txn_is_io = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [63:0] txn_addr = 64'h0000_0000_0000_0000;
    logic [31:0] reg_rdata;
    logic reg_rvalid, txn_claim, txn_window, fwd_valid, fwd_window;
    logic [63:0] fwd_addr, got_addr;
    logic [DEST_W-1:0] fwd_dest, got_dest;
    logic [PAGE_W-1:0] fwd_page;
    int got_count;
    int fail_count = 0;
    int n_compared = 0;
    // ordinary cases: window A translates (size 3), window B passes through (size 0)
    row_t rows[7] = '{
        '{64'h0000_0000_A000_A123, 1'b0, 1'b0, 1'b1, 1'b0, 64'h0000_0001_4000_0123, 4'h3, 5'h05},
        '{64'h0000_0000_A003_FFFF, 1'b0, 1'b0, 1'b1, 1'b0, 64'h0000_0000_8000_1FFF, 4'h7, 5'h1F},
        '{64'h0000_0000_A004_0000, 1'b0, 1'b0, 1'b0, 1'b0, 64'h0, 4'h0, 5'h00},
        '{64'h0000_0000_A000_A123, 1'b0, 1'b1, 1'b0, 1'b0, 64'h0, 4'h0, 5'h00},
        '{64'h0000_0001_A000_A123, 1'b1, 1'b0, 1'b0, 1'b0, 64'h0, 4'h0, 5'h00},
        '{64'h0000_0005_1234_883F, 1'b1, 1'b0, 1'b1, 1'b1, 64'h0000_0005_1234_883F, 4'hA, 5'h02},
        '{64'h0000_0000_1234_883F, 1'b0, 1'b0, 1'b0, 1'b0, 64'h0, 4'h0, 5'h00}};

    inwin_decode i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .txn_valid(txn_valid),
        .txn_addr(txn_addr), .txn_dac(txn_dac), .txn_is_io(txn_is_io),
        .txn_claim(txn_claim), .txn_window(txn_window), .fwd_valid(fwd_valid),
        .fwd_addr(fwd_addr), .fwd_dest(fwd_dest), .fwd_window(fwd_window), .fwd_page(fwd_page));
    fabric_sink i_sink (.sys_clk(sys_clk), .rst_n(rst_n), .fwd_valid(fwd_valid),
        .fwd_addr(fwd_addr), .fwd_dest(fwd_dest), .got_addr(got_addr),
        .got_dest(got_dest), .got_count(got_count));

    // 100 ns period
    always #50 sys_clk = ~sys_clk;

    task automatic bad(input string m);
        fail_count++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic check_reg(input logic [31:0] g, input logic [31:0] e, input string m);
        n_compared++;
        if (g !== e) bad(m);
    endtask
    task automatic check_flag(input logic g, input logic e, input string m);
        n_compared++;
        if (g !== e) bad(m);
    endtask
    task automatic check_fwd(input logic [63:0] g, input logic [63:0] e, input string m);
        n_compared++;
        if (g !== e) bad(m);
    endtask
    // one-cycle write strobe, taken at the next edge
    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
    endtask
    // read answer stands one cycle only, so look at it in that cycle
    task automatic reg_read(input logic [11:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        @(negedge sys_clk);
        check_flag(reg_rvalid, 1'b1, "read valid");
        check_reg(reg_rdata, e, "read data");
    endtask
    // one transaction, claim seen same cycle, forward two cycles later
    task automatic drive(input row_t r);
        @(posedge sys_clk);
        txn_valid <= 1'b1;
        txn_addr <= r.a;
        txn_dac <= r.dac;
        txn_is_io <= r.io;
        @(negedge sys_clk);
        check_flag(txn_claim, r.claim, "claim");
        if (r.claim) check_flag(txn_window, r.win, "window");
        @(posedge sys_clk);
        txn_valid <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check_flag(fwd_valid, r.claim, "forward valid");
        if (r.claim) begin
            check_fwd(fwd_addr, r.fa, "forward address");
            check_fwd({60'h0, fwd_dest}, {60'h0, r.dest}, "destination");
            check_fwd({59'h0, fwd_page}, {59'h0, r.pg}, "page");
            check_flag(fwd_window, r.win, "forward window");
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d, comparisons %0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        #2_000_000;
        bad("timeout");
        summarize();
    end

    initial begin
        row_t r;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        reg_read(SIZING_OFF, 32'h0000_0000);
        reg_write(ORIGIN_A_OFF, 32'hA000_0000);
        reg_write(ORIGIN_B_HI_OFF, 32'h0000_0005);
        reg_read(ORIGIN_A_OFF, 32'h0000_000C);
        reg_read(ORIGIN_B_HI_OFF, 32'h0000_0000);
        reg_write(SIZING_OFF, 32'h000D_1800);
        reg_read(SIZING_OFF, 32'h000D_1800);
        reg_write(ORIGIN_A_OFF, 32'hA000_7FFF);
        reg_write(ORIGIN_A_HI_OFF, 32'h0000_0000); // 32-bit window keeps high zero
        reg_write(ORIGIN_B_OFF, 32'h1234_8000);
        reg_write(ORIGIN_B_HI_OFF, 32'h0000_0005);
        reg_read(ORIGIN_A_OFF, 32'hA000_000C);
        reg_read(ORIGIN_B_HI_OFF, 32'h0000_0005);
        reg_read(ORIGIN_B_OFF, 32'h1234_800C);
        reg_read(12'h100, 32'h0000_0000);
        // lookup entries: A page 5 and 31, B page 2
        reg_write(12'h528, 32'h4000_0003);
        reg_write(12'h52C, 32'h0000_0001);
        reg_write(12'h5F8, 32'h8000_0007);
        reg_write(12'h5FC, 32'h0000_0000);
        reg_write(12'h610, 32'h0000_000A);
        reg_write(12'h614, 32'h0000_0000);
        reg_read(12'h528, 32'h0000_0000);
        foreach (rows[i]) drive(rows[i]);
        check_fwd(64'(got_count), 64'd3, "forward count");
        check_fwd(got_addr, rows[5].fa, "sink address");
        check_fwd({60'h0, got_dest}, {60'h0, rows[5].dest}, "sink destination");
        // back-to-back claims on both windows
        @(posedge sys_clk);
        txn_valid <= 1'b1;
        txn_addr <= rows[0].a;
        @(negedge sys_clk);
        check_flag(txn_window, 1'b0, "first window");
        @(posedge sys_clk);
        txn_addr <= rows[5].a;
        txn_dac <= 1'b1;
        @(negedge sys_clk);
        check_flag(txn_window, 1'b1, "second window");
        @(posedge sys_clk);
        txn_valid <= 1'b0;
        @(negedge sys_clk);
        check_fwd({59'h0, fwd_page}, 64'd5, "first page");
        @(negedge sys_clk);
        check_fwd(fwd_addr, rows[5].fa, "second address");
        // window A disabled: no claim and origin frozen
        r = rows[0];
        r.claim = 1'b0;
        reg_write(SIZING_OFF, 32'h000C_0000);
        reg_write(ORIGIN_A_OFF, 32'h5000_0000);
        reg_read(ORIGIN_A_OFF, 32'hA000_000C);
        drive(r);
        // second reset in mid-run
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        reg_read(SIZING_OFF, 32'h0000_0000);
        drive(r);
        summarize();
    end
endmodule
